// ===== src/lrb_pkg.sv
// Shared constants and carrier types for the refresh bank tracker.
// Assumes a single system clock; all link pins arrive unsynchronised.
`default_nettype none

package lrb_pkg;

  localparam int NBANK = 8;
  localparam int BA_W  = 3;
  localparam int ROW_W = 16;
  localparam int TM_W  = 10;

  // First-edge command codes on CA[4:0]
  localparam logic [4:0] CA_REF  = 5'h08;
  localparam logic [4:0] CA_PRE  = 5'h10;
  localparam logic [1:0] CA_ACT  = 2'h1;
  localparam int         CA_ALL  = 5;

  localparam logic [BA_W-1:0]  BANK_LAST = 3'h7;
  localparam logic [BA_W-1:0]  BANK_ONE  = 3'h1;
  localparam logic [TM_W-1:0]  TM_ZERO   = 10'h000;
  localparam logic [TM_W-1:0]  TM_ONE    = 10'h001;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_REF_PB,
    CMD_REF_AB,
    CMD_ACT,
    CMD_PRE,
    CMD_PRE_ALL
  } lrb_cmd_e;

  typedef struct packed {
    logic       ck;
    logic       cs;
    logic [5:0] ca;
  } lrb_pins_s;

  // Spacings in link clock cycles
  typedef struct packed {
    logic [TM_W-1:0] t_rfcab;
    logic [TM_W-1:0] t_rfcpb;
    logic [TM_W-1:0] t_rp;
    logic [TM_W-1:0] t_rrd;
  } lrb_timing_s;

  typedef struct packed {
    logic             valid;
    logic             all;
    logic [BA_W-1:0]  bank;
    logic [ROW_W-1:0] row;
  } lrb_ref_s;

  typedef struct packed {
    logic [2:0]                  ck_sy;
    logic                        cs_s1;
    logic                        cs_s2;
    logic [5:0]                  ca_s1;
    logic [5:0]                  ca_s2;
    lrb_cmd_e                    pend;
    logic [BA_W-1:0]             bank_cnt;
    logic [NBANK-1:0]            done;
    logic [NBANK-1:0]            open;
    logic [ROW_W-1:0]            row;
    logic                        adv;
    logic [NBANK-1:0][TM_W-1:0]  pb_tmr;
    logic [NBANK-1:0][TM_W-1:0]  rp_tmr;
    logic [TM_W-1:0]             ab_tmr;
    logic [TM_W-1:0]             pbany_tmr;
    logic [TM_W-1:0]             rrd_tmr;
    lrb_ref_s                    ev;
    logic                        illegal;
  } lrb_state_s;

  localparam lrb_state_s LRB_ST_RST = '0;

endpackage

`default_nettype wire

// ===== src/lrb_refresh_track.sv
// Refresh decode, bank and row counters, and refresh spacing checks.
// Assumes the link clock is slow against clock and sref_exit is on clock.
//
// What this block does
// - Decode REFRESH from CS and CA0-CA4.
// - CA5 picks single-bank or all-bank refresh.
// - Bank taken from CA0-CA2 second edge.
// - Reset, self-refresh exit, REFab clear count.
// - REFab clears count, refreshes all banks.
// - Row advances after REFab or bank wrap.
// - Target bank busy, others usable.
// - REFab refreshes all banks, needs idle.
// - Wait all-bank cycle after REFab.
// - REFab accepted mid-round once all banks are idle and the all-bank, per-bank and precharge spacings have run out; t_rrd is not checked.
`default_nettype none

module lrb_refresh_track (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  // Command/address pins
  input  wire lrb_pkg::lrb_pins_s      pins,
  // Programmed spacings
  input  wire lrb_pkg::lrb_timing_s    timing,
  // Self-refresh exit event
  input  wire logic                    sref_exit,
  // Status
  output var  lrb_pkg::lrb_ref_s       refresh,
  output var  logic                    illegal,
  output var  logic [lrb_pkg::BA_W-1:0]  bank_cnt,
  output var  logic [lrb_pkg::ROW_W-1:0] row_cnt,
  output var  logic [lrb_pkg::NBANK-1:0] bank_busy
);
  import lrb_pkg::*;

  lrb_state_s        q;
  lrb_state_s        d;
  logic              rise;
  logic              bad;
  logic [BA_W-1:0]   ba;
  logic [ROW_W-1:0]  rnext;

  //////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [TM_W-1:0] sat_dec(input logic [TM_W-1:0] v);
    sat_dec = (v == TM_ZERO) ? TM_ZERO : TM_W'(v - TM_ONE);
  endfunction

  function automatic logic [ROW_W-1:0] row_use(input logic [ROW_W-1:0] r,
                                               input logic adv);
    row_use = ROW_W'(r + {{(ROW_W-1){1'b0}}, adv});
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Next state

  // Edge found on synchronised copies only; stage 0 feeds stage 1 alone
  assign rise = q.ck_sy[1] & ~q.ck_sy[2];

  always_comb begin
    d     = q;
    bad   = 1'b0;
    rnext = '0;
    ba    = q.ca_s2[BA_W-1:0];
    d.ck_sy = {q.ck_sy[1:0], pins.ck};
    d.cs_s1 = pins.cs;
    d.cs_s2 = q.cs_s1;
    d.ca_s1 = pins.ca;
    d.ca_s2 = q.ca_s1;
    d.ev.valid = 1'b0;
    d.illegal  = 1'b0;

    if (rise) begin
      for (int b = 0; b < NBANK; b++) begin
        d.pb_tmr[b] = sat_dec(q.pb_tmr[b]);
        d.rp_tmr[b] = sat_dec(q.rp_tmr[b]);
      end
      d.ab_tmr    = sat_dec(q.ab_tmr);
      d.pbany_tmr = sat_dec(q.pbany_tmr);
      d.rrd_tmr   = sat_dec(q.rrd_tmr);

      if (q.pend == CMD_NONE) begin
        d.pend = CMD_NONE;
        if (q.cs_s2) begin
          if (q.ca_s2[4:0] == CA_REF) begin
            d.pend = q.ca_s2[CA_ALL] ? CMD_REF_AB : CMD_REF_PB;
          end else if (q.ca_s2[1:0] == CA_ACT) begin
            d.pend = CMD_ACT;
          end else if (q.ca_s2[4:0] == CA_PRE) begin
            d.pend = q.ca_s2[CA_ALL] ? CMD_PRE_ALL : CMD_PRE;
          end
        end
      end else begin
        d.pend = CMD_NONE;
        unique case (q.pend)
          CMD_REF_PB: begin
            bad = q.done[ba] | q.open[ba] |
                  (d.pb_tmr[ba] != TM_ZERO) |
                  (d.pbany_tmr != TM_ZERO) |
                  (d.ab_tmr != TM_ZERO) |
                  (d.rp_tmr[ba] != TM_ZERO) |
                  (d.rrd_tmr != TM_ZERO);
            if (bad) begin
              d.illegal = 1'b1;
            end else begin
              rnext      = row_use(q.row, q.adv);
              d.row      = rnext;
              d.adv      = 1'b0;
              d.ev.valid = 1'b1;
              d.ev.all   = 1'b0;
              d.ev.bank  = ba;
              d.ev.row   = rnext;
              d.pb_tmr[ba] = timing.t_rfcpb;
              d.pbany_tmr  = timing.t_rfcpb;
              d.rrd_tmr    = timing.t_rrd;
              if (q.bank_cnt == BANK_LAST) begin
                d.bank_cnt = '0;
                d.done     = '0;
                d.adv      = 1'b1;
              end else begin
                d.bank_cnt = BA_W'(q.bank_cnt + BANK_ONE);
                d.done[ba] = 1'b1;
              end
            end
          end
          CMD_REF_AB: begin
            bad = (q.open != '0) |
                  (d.ab_tmr != TM_ZERO) |
                  (d.pbany_tmr != TM_ZERO) |
                  (d.rp_tmr != '0);
            if (bad) begin
              d.illegal = 1'b1;
            end else begin
              rnext      = row_use(q.row, q.adv);
              d.row      = rnext;
              d.ev.valid = 1'b1;
              d.ev.all   = 1'b1;
              d.ev.bank  = '0;
              d.ev.row   = rnext;
              // next refresh uses row plus one
              d.adv      = 1'b1;
              d.bank_cnt = '0;
              d.done     = '0;
              d.ab_tmr   = timing.t_rfcab;
            end
          end
          CMD_ACT: begin
            bad = q.open[ba] |
                  (d.pb_tmr[ba] != TM_ZERO) |
                  (d.ab_tmr != TM_ZERO) |
                  (d.rrd_tmr != TM_ZERO);
            if (bad) begin
              d.illegal = 1'b1;
            end else begin
              d.open[ba] = 1'b1;
              d.rrd_tmr  = timing.t_rrd;
            end
          end
          CMD_PRE: begin
            d.open[ba]   = 1'b0;
            d.rp_tmr[ba] = timing.t_rp;
          end
          CMD_PRE_ALL: begin
            d.open = '0;
            for (int b = 0; b < NBANK; b++) begin
              d.rp_tmr[b] = timing.t_rp;
            end
          end
          CMD_NONE: begin
          end
        endcase
      end
    end

    if (sref_exit) begin
      d.bank_cnt = '0;
      d.done     = '0;
      d.open     = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q <= LRB_ST_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  assign refresh  = q.ev;
  assign illegal  = q.illegal;
  assign bank_cnt = q.bank_cnt;
  assign row_cnt  = q.row;

  // Busy covers both refresh kinds; other banks stay usable
  always_comb begin
    for (int b = 0; b < NBANK; b++) begin
      bank_busy[b] = (q.pb_tmr[b] != TM_ZERO) | (q.ab_tmr != TM_ZERO);
    end
  end

endmodule // lrb_refresh_track

`default_nettype wire

// ===== tb/lrb_ctrl_model.sv
// Controller model driving the link clock, select and command pins.
// Assumes one caller at a time; link clock stands low between frames.
`default_nettype none
module lrb_ctrl_model (
  // Link pins
  output var lrb_pkg::lrb_pins_s pins
);
  timeunit 1ns;
  timeprecision 100ps;
  import lrb_pkg::*;
  initial pins = '0;
  ////////////////
  // two-edge command
  // no WRITE or READ is ever sent, so write-to-read spacing holds
  // Half-ns offset keeps link edges off the rising clock edges
  task automatic send(input logic c, input logic [5:0] a1, input logic [5:0] a2);
    pins.cs = c;
    pins.ca = a1;
    #32.5 pins.ck = 1'b1;
    #32 pins.ck = 1'b0;
    pins.ca = a2;
    #32 pins.ck = 1'b1;
    #32 pins.ck = 1'b0;
    pins.cs = 1'b0;
    pins.ca = ~a2;
  endtask
endmodule // lrb_ctrl_model
`default_nettype wire

// ===== tb/lrb_track_props.sv
// Checker of refresh counts and rows at the tracker ports.
// Assumes one clock domain, synchronous active-low reset.
`default_nettype none
module lrb_track_props (
  // Clock and reset
  input wire logic                      clock,
  input wire logic                      reset_n,
  // Watched ports
  input wire logic                      sref_exit,
  input wire lrb_pkg::lrb_ref_s         refresh,
  input wire logic                      illegal,
  input wire logic [lrb_pkg::BA_W-1:0]  bank_cnt,
  input wire logic [lrb_pkg::ROW_W-1:0] row_cnt,
  input wire logic [lrb_pkg::NBANK-1:0] bank_busy
);
  import lrb_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  ////////////////
  a_valid_pulse: assert property (refresh.valid |=> !refresh.valid) else $error("long pulse");
  a_not_both: assert property (!(refresh.valid && illegal)) else $error("accept and refuse");
  a_ab_clear: assert property (refresh.valid && refresh.all
    |-> bank_cnt == 3'h0 && bank_busy == 8'hFF && refresh.bank == 3'h0) else $error("all-bank state");
  a_pb_count: assert property (refresh.valid && !refresh.all && !$past(sref_exit)
    |-> bank_cnt == $past(bank_cnt) + 3'h1) else $error("count step");
  a_pb_busy: assert property (refresh.valid && !refresh.all |-> bank_busy[refresh.bank])
    else $error("bank not busy");
  a_row_report: assert property (refresh.valid |-> row_cnt == refresh.row) else $error("row out");
  a_ill_keep: assert property (illegal && !$past(sref_exit) |-> $stable(bank_cnt) && $stable(row_cnt))
    else $error("refused changed counts");
  a_cnt_hold: assert property (!refresh.valid && !$past(sref_exit) |-> $stable(bank_cnt))
    else $error("count moved");
  a_sref_clear: assert property (sref_exit |=> bank_cnt == 3'h0) else $error("sync missed");
  a_row_same: assert property (refresh.valid && $past(bank_cnt) != 3'h0
    |-> refresh.row == $past(row_cnt)) else $error("row moved mid round");
endmodule // lrb_track_props
bind lrb_refresh_track lrb_track_props i_lrb_track_props (.clock(clock), .reset_n(reset_n),
  .sref_exit(sref_exit), .refresh(refresh), .illegal(illegal), .bank_cnt(bank_cnt), .row_cnt(row_cnt),
  .bank_busy(bank_busy));
`default_nettype wire

// ===== tb/tb_top.sv
// Bench: refresh rounds, all-bank refresh, sync events, open bank.
// Assumes the controller model drives the pins; checker is bound.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lrb_pkg::*;
  logic             clock = 1'b0;
  logic             reset_n = 1'b0;
  logic             sref_exit = 1'b0;
  logic             illegal, got_v, got_i;
  lrb_pins_s        pins;
  lrb_timing_s      timing = '{10'h004, 10'h004, 10'h003, 10'h003};
  lrb_ref_s         refresh, last;
  logic [BA_W-1:0]  bank_cnt;
  logic [ROW_W-1:0] row_cnt;
  logic [NBANK-1:0] bank_busy, busy_at;
  logic [2:0]       order [8] = '{3'h1, 3'h3, 3'h0, 3'h2, 3'h4, 3'h7, 3'h5, 3'h6};
  int               fails = 0;
  int               cmp_count = 0;
  int               cycles = 0;
  lrb_refresh_track i_lrb_refresh_track (.clock(clock), .reset_n(reset_n), .pins(pins), .timing(timing),
    .sref_exit(sref_exit), .refresh(refresh), .illegal(illegal), .bank_cnt(bank_cnt), .row_cnt(row_cnt),
    .bank_busy(bank_busy));
  lrb_ctrl_model i_lrb_ctrl_model (.pins(pins));
  always #2.5 clock = ~clock;
  ////////////////
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (refresh.valid === 1'b1) begin
      got_v <= 1'b1;
      last <= refresh;
      busy_at <= bank_busy;
    end
    if (illegal === 1'b1) got_i <= 1'b1;
    if (cycles == 4000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic nop();
    got_v = 1'b0;
    i_lrb_ctrl_model.send(1'b0, {1'b1, CA_REF}, 6'h00);
    @(posedge clock) #1;
    chk(got_v, 1'b0);
  endtask
  task automatic rf(input logic all, input logic [2:0] b, input logic ok, input logic [15:0] r);
    got_v = 1'b0;
    got_i = 1'b0;
    i_lrb_ctrl_model.send(1'b1, {all, CA_REF}, {3'h0, b});
    @(posedge clock) #1;
    chk({got_v, got_i}, {ok, !ok});
    if (ok) chk({last.all, last.bank, last.row}, {all, all ? 3'h0 : b, r});
  endtask
  // Activate and precharge frames: never a refresh event, refused only when ok is low
  task automatic act(input logic [5:0] a1, input logic [5:0] a2, input logic ok);
    got_v = 1'b0;
    got_i = 1'b0;
    i_lrb_ctrl_model.send(1'b1, a1, a2);
    @(posedge clock) #1;
    chk({got_v, got_i}, {1'b0, !ok});
  endtask
  ////////////////
  task automatic t_round();
    for (int i = 0; i < 8; i++) begin
      if (i == 5) rf(1'b0, order[i], 1'b0, 16'h0000);
      nop();
      if (i == 3) rf(1'b0, 3'h3, 1'b0, 16'h0000);
      rf(1'b0, order[i], 1'b1, 16'h0000);
      chk(busy_at[order[i]], 1'b1);
      chk(bank_cnt, (i + 1) % 8);
    end
    nop();
    rf(1'b0, 3'h6, 1'b1, 16'h0001);
    $display("t_round done");
  endtask
  task automatic t_ab();
    nop();
    rf(1'b0, 3'h7, 1'b1, 16'h0001);
    nop();
    rf(1'b1, 3'h5, 1'b1, 16'h0001);
    chk({bank_cnt, busy_at}, 11'h0FF);
    rf(1'b0, 3'h6, 1'b0, 16'h0000);
    nop();
    rf(1'b0, 3'h6, 1'b1, 16'h0002);
    $display("t_ab done");
  endtask
  task automatic t_sref();
    sref_exit = 1'b1;
    @(posedge clock) #1 sref_exit = 1'b0;
    @(posedge clock) #1 chk(bank_cnt, 3'h0);
    nop();
    rf(1'b0, 3'h6, 1'b1, 16'h0002);
    chk(bank_cnt, 3'h1);
    $display("t_sref done");
  endtask
  task automatic t_act();
    act(6'h01, 6'h06, 1'b0);
    nop();
    act(6'h01, 6'h02, 1'b1);
    nop();
    rf(1'b1, 3'h0, 1'b0, 16'h0000);
    act({1'b0, CA_PRE}, 6'h02, 1'b1);
    rf(1'b1, 3'h0, 1'b0, 16'h0000);
    nop();
    rf(1'b1, 3'h0, 1'b1, 16'h0002);
    nop();
    act(6'h01, 6'h01, 1'b1);
    act({1'b1, CA_PRE}, 6'h00, 1'b1);
    rf(1'b1, 3'h0, 1'b0, 16'h0000);
    nop();
    rf(1'b1, 3'h0, 1'b1, 16'h0003);
    $display("t_act done");
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clock);
    #1 chk({bank_cnt, row_cnt, bank_busy}, 32'h0);
    t_round();
    t_ab();
    t_sref();
    t_act();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
